//--- boot_sw_model.sv
// Boot software stand-in: a classic Wishbone master for register moves.
// Assumes one clock; the testbench calls xfer hierarchically.
`timescale 1ns/100ps
module boot_sw_model (
  // Clock
  input wire logic i_clk,
  // Slave answer
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [31:0] i_dat,
  // Request
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [7:0] o_adr,
  output logic [3:0] o_sel,
  output logic [31:0] o_dat
);
  int timeouts = 0;

  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'h0;
    o_dat = 32'h0000_0000;
  end

  // Released write data shows the inverse so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= w;
    o_adr <= a;
    o_sel <= 4'hF;
    o_dat <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && i_err !== 1'b1 && n < 50);
    q = i_dat;
    e = i_err;
    if (n >= 50) timeouts++;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we <= 1'b0;
    o_dat <= ~d;
  endtask : xfer
endmodule : boot_sw_model

//--- post_reset_config_pkg.sv
// Constants for the post-reset configuration register bank.
// Assumes a 32-bit classic Wishbone bus and a 10 MHz core clock.
package post_reset_config_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] GUARDED_OFS = 8'h00;
  localparam logic [7:0] ENDIAN_OFS = 8'h04;
  localparam logic [7:0] USER_OFS = 8'h08;
  localparam logic [7:0] ICC_OFS = 8'h0C;
  localparam logic [7:0] DCC_OFS = 8'h10;
  localparam logic [7:0] WPOL_OFS = 8'h14;
  localparam logic [7:0] VBASE_OFS = 8'h18;
  localparam logic [7:0] TCTL_OFS = 8'h1C;
  localparam logic [7:0] TSTAT_OFS = 8'h20;
  localparam logic [7:0] ITMR_OFS = 8'h24;
  localparam logic [7:0] TBLO_OFS = 8'h28;
  localparam logic [7:0] TBHI_OFS = 8'h2C;
  localparam logic [7:0] MSTATE_OFS = 8'h30;
  localparam logic [7:0] CMD_OFS = 8'h34;
  localparam logic [7:0] DINV_OFS = 8'h38;
  localparam logic [7:0] STAT_OFS = 8'h3C;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] GUARDED_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  localparam logic [31:0] FIRST_FETCH = 32'hFFFF_FFFC;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MST_CE_BIT = 17;
  localparam int MST_EE_BIT = 15;
  localparam int TMR_ITV_BIT = 0;
  localparam int TMR_FIT_BIT = 1;
  localparam int TB_FIT_BIT = 9;
  localparam int CMD_IFLASH_BIT = 0;
  localparam int STAT_ICLEAN_BIT = 0;
  localparam int STAT_DCLEAN_BIT = 1;
  localparam int STAT_RUN_BIT = 2;

  // ****************************************************************
  // Data cache geometry and timing
  // ****************************************************************
  localparam int DC_CLASSES = 256;
  localparam int DC_LINE_BYTES = 32;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_HZ = 1_000_000;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int INIT_NS = 1_000;
  localparam int INIT_CYCLES = INIT_NS / 100;

  typedef enum logic {INIT_S, RUN_S} boot_state_t;

endpackage : post_reset_config_pkg

//--- post_reset_config_state.sv
// Post-reset configuration register bank for the processor core.
// Assumes a classic Wishbone master and synchronous core-side inputs.
//
// Overview of operation
// - every region is guarded after reset, blocking speculative fetch
// - guarded attribute register resets to all ones
// - all regions start big-endian until software sets endian bits
// - user-defined storage attributes reset disabled
// - icache content undefined at reset; invalidate before enabling
// - icache cacheability register clears on reset
// - write policy selects write-back per region, only where cacheable
// - dcache cacheability register clears on reset
// - internal exceptions are always enabled, never masked
// - vector prefix holds handler table base, loaded before enabling
// - timer exceptions deliverable once the external enable and the timer control enable are set
// - external exceptions enabled only by machine state enable bits
// - first fetch after hardware init is from the top word
// - cache-invalidate command flash-invalidates the whole icache
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module post_reset_config_state
  import post_reset_config_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_WB_ERR,
  // Exception sources
  input wire logic I_INT_EXC,
  input wire logic I_CRIT_IRQ,
  input wire logic I_EXT_IRQ,
  // Core-side controls
  output logic [31:0] O_GUARDED,
  output logic [31:0] O_LITTLE_ENDIAN,
  output logic [31:0] O_USER_ATTR,
  output logic [31:0] O_ICACHEABLE,
  output logic [31:0] O_DCACHEABLE,
  output logic [31:0] O_DCACHE_WRITE_BACK,
  output logic [31:0] O_VECTOR_BASE,
  output logic O_INT_EXC,
  output logic O_CRIT_EXC,
  output logic O_NONCRIT_EXC,
  output logic O_ICACHE_FLASH_INV,
  output logic O_DCACHE_INV,
  output logic [31:0] O_DCACHE_INV_ADDR,
  output logic O_FETCH_REQ,
  output logic [31:0] O_FETCH_ADDR
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [31:0] guarded_q, guarded_d, endian_q, endian_d;
  logic [31:0] user_q, user_d, icc_q, icc_d, dcc_q, dcc_d;
  logic [31:0] wpol_q, wpol_d, vbase_q, vbase_d, tctl_q, tctl_d;
  logic [31:0] tstat_q, tstat_d, itmr_q, itmr_d, tblo_q, tblo_d;
  logic [31:0] tbhi_q, tbhi_d, mstate_q, mstate_d, rdat_q, rdat_d;
  logic [31:0] dinv_addr_q, dinv_addr_d;
  logic [8:0] dclass_q, dclass_d;
  logic [3:0] tick_cnt_q, tick_cnt_d;
  logic [3:0] init_cnt_q, init_cnt_d;
  logic ack_q, ack_d, err_q, err_d, iclean_q, iclean_d;
  logic iflash_q, iflash_d, dinv_q, dinv_d, fetch_q, fetch_d;
  boot_state_t state_q, state_d;

  logic req, wr, rd_hit, tick, itv_event, fit_event;
  logic [31:0] wmask, tb_next;

  assign req = I_WB_CYC && I_WB_STB && !ack_q && !err_q;
  assign wr = req && I_WB_WE;
  assign wmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                  {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
  assign tick = (tick_cnt_q == 4'(TICK_DIV - 1));
  assign tb_next = tblo_q + 32'h0000_0001;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    guarded_d = guarded_q;
    endian_d = endian_q;
    user_d = user_q;
    icc_d = icc_q;
    dcc_d = dcc_q;
    wpol_d = wpol_q;
    vbase_d = vbase_q;
    tctl_d = tctl_q;
    tstat_d = tstat_q;
    itmr_d = itmr_q;
    tblo_d = tblo_q;
    tbhi_d = tbhi_q;
    mstate_d = mstate_q;
    rdat_d = rdat_q;
    dinv_addr_d = dinv_addr_q;
    dclass_d = dclass_q;
    iclean_d = iclean_q;
    state_d = state_q;
    init_cnt_d = init_cnt_q;
    tick_cnt_d = tick ? 4'h0 : tick_cnt_q + 4'h1;
    iflash_d = 1'b0;
    dinv_d = 1'b0;
    fetch_d = 1'b0;
    itv_event = 1'b0;
    fit_event = 1'b0;
    ack_d = req;
    err_d = 1'b0;
    rd_hit = 1'b1;

    // Hardware init, then one fetch from the top word
    unique case (state_q)
      INIT_S: begin
        if (init_cnt_q == 4'(INIT_CYCLES - 1)) begin
          state_d = RUN_S;
          fetch_d = 1'b1;
        end else begin
          init_cnt_d = init_cnt_q + 4'h1;
        end
      end
      RUN_S: begin
      end
    endcase

    // Time base and interval timer run on the divided tick
    if (tick) begin
      tblo_d = tb_next;
      if (tb_next == ZERO_RST) begin
        tbhi_d = tbhi_q + 32'h0000_0001;
      end
      fit_event = tb_next[TB_FIT_BIT] && !tblo_q[TB_FIT_BIT];
      if (itmr_q != ZERO_RST) begin
        itmr_d = itmr_q - 32'h0000_0001;
        itv_event = (itmr_q == 32'h0000_0001);
      end
    end

    // Bus reads
    unique case (I_WB_ADR)
      GUARDED_OFS: rdat_d = guarded_q;
      ENDIAN_OFS: rdat_d = endian_q;
      USER_OFS: rdat_d = user_q;
      ICC_OFS: rdat_d = icc_q;
      DCC_OFS: rdat_d = dcc_q;
      WPOL_OFS: rdat_d = wpol_q;
      VBASE_OFS: rdat_d = vbase_q;
      TCTL_OFS: rdat_d = tctl_q;
      TSTAT_OFS: rdat_d = tstat_q;
      ITMR_OFS: rdat_d = itmr_q;
      TBLO_OFS: rdat_d = tblo_q;
      TBHI_OFS: rdat_d = tbhi_q;
      MSTATE_OFS: rdat_d = mstate_q;
      CMD_OFS: rdat_d = ZERO_RST;
      DINV_OFS: rdat_d = dinv_addr_q;
      STAT_OFS: begin
        rdat_d = ZERO_RST;
        rdat_d[STAT_ICLEAN_BIT] = iclean_q;
        rdat_d[STAT_DCLEAN_BIT] = (dclass_q == 9'(DC_CLASSES));
        rdat_d[STAT_RUN_BIT] = (state_q == RUN_S);
      end
      default: begin
        rdat_d = ZERO_RST;
        rd_hit = 1'b0;
      end
    endcase
    if (req && !rd_hit) begin
      ack_d = 1'b0;
      err_d = 1'b1;
    end

    // Bus writes; a software write wins over the timer count
    if (wr && rd_hit) begin
      unique case (I_WB_ADR)
        GUARDED_OFS: guarded_d = merge(guarded_q, I_WB_DAT, wmask);
        ENDIAN_OFS: endian_d = merge(endian_q, I_WB_DAT, wmask);
        USER_OFS: user_d = merge(user_q, I_WB_DAT, wmask);
        ICC_OFS: icc_d = merge(icc_q, I_WB_DAT, wmask);
        DCC_OFS: dcc_d = merge(dcc_q, I_WB_DAT, wmask);
        WPOL_OFS: wpol_d = merge(wpol_q, I_WB_DAT, wmask);
        VBASE_OFS: vbase_d = merge(vbase_q, I_WB_DAT, wmask);
        TCTL_OFS: tctl_d = merge(tctl_q, I_WB_DAT, wmask);
        TSTAT_OFS: tstat_d = tstat_q & ~(I_WB_DAT & wmask);
        ITMR_OFS: itmr_d = merge(itmr_q, I_WB_DAT, wmask);
        TBLO_OFS: tblo_d = merge(tblo_q, I_WB_DAT, wmask);
        TBHI_OFS: tbhi_d = merge(tbhi_q, I_WB_DAT, wmask);
        MSTATE_OFS: mstate_d = merge(mstate_q, I_WB_DAT, wmask);
        CMD_OFS: begin
          if (I_WB_SEL[0] && I_WB_DAT[CMD_IFLASH_BIT]) begin
            iflash_d = 1'b1;
            iclean_d = 1'b1;
          end
        end
        DINV_OFS: begin
          dinv_addr_d = I_WB_DAT;
          dinv_d = 1'b1;
          // Clean only after every class is visited in order
          if (dclass_q != 9'(DC_CLASSES) && I_WB_DAT ==
              32'(dclass_q) * 32'(DC_LINE_BYTES)) begin
            dclass_d = dclass_q + 9'h001;
          end
        end
        default: begin
        end
      endcase
    end

    // Timer flags are sticky; an event beats a same-cycle clear
    if (itv_event) begin
      tstat_d[TMR_ITV_BIT] = 1'b1;
    end
    if (fit_event) begin
      tstat_d[TMR_FIT_BIT] = 1'b1;
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      guarded_q <= GUARDED_RST;
      endian_q <= ZERO_RST;
      user_q <= ZERO_RST;
      icc_q <= ZERO_RST;
      dcc_q <= ZERO_RST;
      wpol_q <= ZERO_RST;
      vbase_q <= ZERO_RST;
      tctl_q <= ZERO_RST;
      tstat_q <= ZERO_RST;
      itmr_q <= ZERO_RST;
      tblo_q <= ZERO_RST;
      tbhi_q <= ZERO_RST;
      mstate_q <= ZERO_RST;
      rdat_q <= ZERO_RST;
      dinv_addr_q <= ZERO_RST;
      dclass_q <= 9'h000;
      tick_cnt_q <= 4'h0;
      init_cnt_q <= 4'h0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      iclean_q <= 1'b0;
      iflash_q <= 1'b0;
      dinv_q <= 1'b0;
      fetch_q <= 1'b0;
      state_q <= INIT_S;
    end else begin
      guarded_q <= guarded_d;
      endian_q <= endian_d;
      user_q <= user_d;
      icc_q <= icc_d;
      dcc_q <= dcc_d;
      wpol_q <= wpol_d;
      vbase_q <= vbase_d;
      tctl_q <= tctl_d;
      tstat_q <= tstat_d;
      itmr_q <= itmr_d;
      tblo_q <= tblo_d;
      tbhi_q <= tbhi_d;
      mstate_q <= mstate_d;
      rdat_q <= rdat_d;
      dinv_addr_q <= dinv_addr_d;
      dclass_q <= dclass_d;
      tick_cnt_q <= tick_cnt_d;
      init_cnt_q <= init_cnt_d;
      ack_q <= ack_d;
      err_q <= err_d;
      iclean_q <= iclean_d;
      iflash_q <= iflash_d;
      dinv_q <= dinv_d;
      fetch_q <= fetch_d;
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_WB_DAT = rdat_q;
  assign O_WB_ACK = ack_q;
  assign O_WB_ERR = err_q;
  assign O_GUARDED = guarded_q;
  assign O_LITTLE_ENDIAN = endian_q;
  assign O_USER_ATTR = user_q;
  assign O_ICACHEABLE = icc_q;
  assign O_DCACHEABLE = dcc_q;
  assign O_DCACHE_WRITE_BACK = wpol_q & dcc_q;
  assign O_VECTOR_BASE = vbase_q;
  // Internal exceptions bypass every enable
  assign O_INT_EXC = I_INT_EXC;
  assign O_CRIT_EXC = I_CRIT_IRQ && mstate_q[MST_CE_BIT];
  assign O_NONCRIT_EXC = mstate_q[MST_EE_BIT] && (I_EXT_IRQ ||
                         |(tstat_q & tctl_q));
  assign O_ICACHE_FLASH_INV = iflash_q;
  assign O_DCACHE_INV = dinv_q;
  assign O_DCACHE_INV_ADDR = dinv_addr_q;
  assign O_FETCH_REQ = fetch_q;
  assign O_FETCH_ADDR = FIRST_FETCH;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  AST_GUARD_RESET: assert property (
    $rose(I_RST_B) |-> O_GUARDED == GUARDED_RST)
    else $error("guarded attributes not all ones after reset");
  AST_NO_GUARD_LOSS: assert property (
    (O_GUARDED != $past(O_GUARDED)) |-> $past(wr) &&
      $past(I_WB_ADR) == GUARDED_OFS)
    else $error("guarded attributes changed without a write");
  AST_ATTR_RESET: assert property (
    $rose(I_RST_B) |-> O_LITTLE_ENDIAN == ZERO_RST &&
      O_USER_ATTR == ZERO_RST)
    else $error("endian or user attributes not clear after reset");
  AST_CACHE_RESET: assert property (
    $rose(I_RST_B) |-> O_ICACHEABLE == ZERO_RST &&
      O_DCACHEABLE == ZERO_RST)
    else $error("cacheability not clear after reset");
  AST_WRITE_POLICY: assert property (
    (O_DCACHE_WRITE_BACK & ~O_DCACHEABLE) == ZERO_RST)
    else $error("write-back shown for non-cacheable region");
  AST_INT_UNMASKED: assert property (
    I_INT_EXC && !mstate_q[MST_EE_BIT] && !mstate_q[MST_CE_BIT] |->
      O_INT_EXC)
    else $error("internal exception was masked");
  AST_TIMER_DELIVER: assert property (
    mstate_q[MST_EE_BIT] && (tstat_q[TMR_ITV_BIT] && tctl_q[TMR_ITV_BIT])
      |-> O_NONCRIT_EXC)
    else $error("enabled timer event not delivered");
  AST_STATE_GATE: assert property (
    !mstate_q[MST_CE_BIT] && !mstate_q[MST_EE_BIT] |->
      !O_CRIT_EXC && !O_NONCRIT_EXC)
    else $error("external exception with enables clear");
  AST_VECTOR_LOAD: assert property (
    wr && I_WB_ADR == VBASE_OFS && I_WB_SEL == 4'hF |=>
      O_VECTOR_BASE == $past(I_WB_DAT))
    else $error("vector base not loaded by write");
  AST_FIRST_FETCH: assert property (
    $rose(I_RST_B) |-> ##[1:20] O_FETCH_REQ &&
      O_FETCH_ADDR == FIRST_FETCH)
    else $error("first fetch not from top word");
  AST_FLASH_INV: assert property (
    wr && I_WB_ADR == CMD_OFS && I_WB_SEL[0] && I_WB_DAT[CMD_IFLASH_BIT]
      |=> O_ICACHE_FLASH_INV && iclean_q ##1 !O_ICACHE_FLASH_INV)
    else $error("flash invalidate not issued for one cycle");
  AST_ITV_STOP: assert property (
    wr && I_WB_ADR == ITMR_OFS && I_WB_SEL == 4'hF &&
      I_WB_DAT == ZERO_RST |=> (itmr_q == ZERO_RST) [*3])
    else $error("interval timer kept running after zero write");

endmodule : post_reset_config_state

//--- tb_top.sv
// Self-checking bench for the post-reset configuration bank.
// Assumes the boot software model drives the Wishbone side.
`timescale 1ns/100ps
module tb_top;
  import post_reset_config_pkg::*;
  logic I_CLK_SYS, I_RST_B, I_INT_EXC, I_CRIT_IRQ, I_EXT_IRQ;
  logic I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK, O_WB_ERR;
  logic [7:0] I_WB_ADR;
  logic [3:0] I_WB_SEL;
  logic [31:0] I_WB_DAT, O_WB_DAT, O_GUARDED, O_LITTLE_ENDIAN, O_USER_ATTR;
  logic [31:0] O_ICACHEABLE, O_DCACHEABLE, O_DCACHE_WRITE_BACK;
  logic [31:0] O_VECTOR_BASE, O_DCACHE_INV_ADDR, O_FETCH_ADDR, q, last_inv;
  logic O_INT_EXC, O_CRIT_EXC, O_NONCRIT_EXC, O_ICACHE_FLASH_INV;
  logic O_DCACHE_INV, O_FETCH_REQ, e;
  int mismatches = 0, n_compared = 0, n_fetch = 0, n_flash = 0, n_dinv = 0;
  localparam logic [31:0] MST_ON = (32'h1 << MST_CE_BIT) |
    (32'h1 << MST_EE_BIT);

  post_reset_config_state u_post_reset_config_state (.I_CLK_SYS, .I_RST_B,
    .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT,
    .O_WB_DAT, .O_WB_ACK, .O_WB_ERR, .I_INT_EXC, .I_CRIT_IRQ, .I_EXT_IRQ,
    .O_GUARDED, .O_LITTLE_ENDIAN, .O_USER_ATTR, .O_ICACHEABLE,
    .O_DCACHEABLE, .O_DCACHE_WRITE_BACK, .O_VECTOR_BASE, .O_INT_EXC,
    .O_CRIT_EXC, .O_NONCRIT_EXC, .O_ICACHE_FLASH_INV, .O_DCACHE_INV,
    .O_DCACHE_INV_ADDR, .O_FETCH_REQ, .O_FETCH_ADDR);

  boot_sw_model u_boot_sw_model (.i_clk(I_CLK_SYS), .i_ack(O_WB_ACK),
    .i_err(O_WB_ERR), .i_dat(O_WB_DAT), .o_cyc(I_WB_CYC), .o_stb(I_WB_STB),
    .o_we(I_WB_WE), .o_adr(I_WB_ADR), .o_sel(I_WB_SEL), .o_dat(I_WB_DAT));

  // Pulse counters: one-cycle outputs are easy to miss by polling
  always @(posedge I_CLK_SYS) begin
    if (O_FETCH_REQ === 1'b1) n_fetch++;
    if (O_ICACHE_FLASH_INV === 1'b1) n_flash++;
    if (O_DCACHE_INV === 1'b1) begin
      n_dinv++;
      last_inv = O_DCACHE_INV_ADDR;
    end
  end

  task automatic summarize;
    mismatches += u_boot_sw_model.timeouts;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_boot_sw_model.xfer(1'b1, a, d, q, e);
    if (u_boot_sw_model.timeouts != 0) summarize();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    u_boot_sw_model.xfer(1'b0, a, 32'h0000_0000, q, e);
    if (u_boot_sw_model.timeouts != 0) summarize();
    chk(q, x);
  endtask : rd

  task automatic drive(input logic c, input logic x, input logic i);
    @(posedge I_CLK_SYS);
    I_CRIT_IRQ <= c;
    I_EXT_IRQ <= x;
    I_INT_EXC <= i;
    @(negedge I_CLK_SYS);
  endtask : drive

  task automatic t_boot(input int k);
    repeat (INIT_CYCLES + 4) @(posedge I_CLK_SYS);
    chk(n_fetch, k);
    chk(O_FETCH_ADDR, FIRST_FETCH);
    chk(O_GUARDED, GUARDED_RST);
    rd(GUARDED_OFS, GUARDED_RST);
    chk(O_LITTLE_ENDIAN, ZERO_RST);
    chk(O_USER_ATTR, ZERO_RST);
    chk(O_ICACHEABLE, ZERO_RST);
    chk(O_DCACHEABLE, ZERO_RST);
    rd(MSTATE_OFS, ZERO_RST);
    $display("test boot done");
  endtask : t_boot

  task automatic t_attr;
    wr(GUARDED_OFS, 32'h0000_00F0);
    chk(O_GUARDED, 32'h0000_00F0);
    wr(ENDIAN_OFS, 32'h8000_0001);
    chk(O_LITTLE_ENDIAN, 32'h8000_0001);
    wr(USER_OFS, 32'h0000_FF00);
    chk(O_USER_ATTR, 32'h0000_FF00);
    rd(8'h40, 32'h0000_0000);
    chk(e, 1'b1);
    $display("test attributes done");
  endtask : t_attr

  task automatic t_caches;
    wr(CMD_OFS, 32'h0000_0001);
    repeat (2) @(posedge I_CLK_SYS);
    chk(n_flash, 1);
    rd(STAT_OFS, 32'h0000_0005);
    wr(ICC_OFS, 32'hC000_0000);
    chk(O_ICACHEABLE, 32'hC000_0000);
    for (int i = 0; i < DC_CLASSES; i++) begin
      wr(DINV_OFS, i * DC_LINE_BYTES);
    end
    // Counter updates in the same step as the last ack; let it settle
    @(negedge I_CLK_SYS);
    chk(n_dinv, DC_CLASSES);
    chk(last_inv, 32'h0000_1FE0);
    rd(STAT_OFS, 32'h0000_0007);
    wr(WPOL_OFS, 32'hF0F0_F0F0);
    wr(DCC_OFS, 32'hFF00_FF00);
    chk(O_DCACHEABLE, 32'hFF00_FF00);
    chk(O_DCACHE_WRITE_BACK, 32'hF000_F000);
    $display("test caches done");
  endtask : t_caches

  task automatic t_exc;
    wr(VBASE_OFS, 32'hFFF0_0000);
    chk(O_VECTOR_BASE, 32'hFFF0_0000);
    // With both machine state enables clear only the internal exception is raised
    drive(1'b1, 1'b1, 1'b1);
    chk(O_INT_EXC, 1'b1);
    chk(O_CRIT_EXC, 1'b0);
    chk(O_NONCRIT_EXC, 1'b0);
    wr(ITMR_OFS, 32'h0000_0000);
    wr(TSTAT_OFS, 32'hFFFF_FFFF);
    wr(TCTL_OFS, 32'h0000_0000);
    wr(TBLO_OFS, 32'h0000_0000);
    wr(TBHI_OFS, 32'h0000_0005);
    wr(TBLO_OFS, 32'h0000_0007);
    rd(TBHI_OFS, 32'h0000_0005);
    wr(MSTATE_OFS, MST_ON);
    chk(O_CRIT_EXC, 1'b1);
    chk(O_NONCRIT_EXC, 1'b1);
    drive(1'b1, 1'b0, 1'b1);
    chk(O_NONCRIT_EXC, 1'b0);
    wr(ITMR_OFS, 32'h0000_0001);
    repeat (3 * TICK_DIV) @(posedge I_CLK_SYS);
    chk(O_NONCRIT_EXC, 1'b0);
    wr(TCTL_OFS, 32'h0000_0001);
    chk(O_NONCRIT_EXC, 1'b1);
    wr(TSTAT_OFS, 32'h0000_0001);
    chk(O_NONCRIT_EXC, 1'b0);
    wr(MSTATE_OFS, 32'h0000_0000);
    chk(O_CRIT_EXC, 1'b0);
    chk(O_INT_EXC, 1'b1);
    drive(1'b0, 1'b0, 1'b0);
    chk(O_INT_EXC, 1'b0);
    $display("test exceptions done");
  endtask : t_exc

  initial begin
    I_CLK_SYS = 1'b0;
    forever #50 I_CLK_SYS = ~I_CLK_SYS;
  end

  initial begin
    I_RST_B = 1'b0;
    I_INT_EXC = 1'b0;
    I_CRIT_IRQ = 1'b0;
    I_EXT_IRQ = 1'b0;
    repeat (12) @(posedge I_CLK_SYS);
    I_RST_B <= 1'b1;
    t_boot(1);
    t_attr();
    t_caches();
    t_exc();
    // Second reset mid-run must restore the attribute, cacheability and machine state reset values
    @(posedge I_CLK_SYS);
    I_RST_B <= 1'b0;
    repeat (2) @(posedge I_CLK_SYS);
    I_RST_B <= 1'b1;
    t_boot(2);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge I_CLK_SYS);
    mismatches++;
    summarize();
  end
endmodule : tb_top
